// >>> core/t1gr_map.svh
// register indices, field positions, reset values and timing for t1gr_regs
`ifndef T1GR_MAP_SVH
`define T1GR_MAP_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define T1GR_IDX_REF_SEL     10'h007
`define T1GR_IDX_LINK_IRQ    10'h009
`define T1GR_IDX_TMR_EN      10'h00A
`define T1GR_IDX_TMR_FLAG    10'h00B
`define T1GR_IDX_WIN_SEL     10'h00E
`define T1GR_IDX_WIN_DATA    10'h00F
`define T1GR_IDX_BP_CFG      10'h010
`define T1GR_IDX_NOSIG_CFG   10'h03E
// per-link offsets, link number sits in index bits 9:8
`define T1GR_OFS_DEJIT       8'h21
`define T1GR_OFS_PWR_CODE    8'h22
`define T1GR_OFS_DRV_SHAPE   8'h23
`define T1GR_OFS_AMP         8'h24
`define T1GR_OFS_TRAM_CTL    8'h25
`define T1GR_OFS_TRAM_DATA   8'h26
`define T1GR_OFS_GAP         8'h38

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define T1GR_DEJ_PEAK   5
`define T1GR_DEJ_WIDE   4
`define T1GR_DEJ_EN     3
`define T1GR_DEJ_DP_HI  2
`define T1GR_DEJ_DP_LO  1
`define T1GR_DEJ_CORNER 0
`define T1GR_DRV_DFM   5
`define T1GR_DRV_FLOAT 4
`define T1GR_TRAM_GO   7
`define T1GR_TRAM_RD   6
`define T1GR_PERF_LAST 4'hB

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define T1GR_RST_BP    5'h16
`define T1GR_RST_DRV   6'h10
`define T1GR_RST_AMP   6'h21

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define T1GR_SEC_TIME_MS 1000
`define T1GR_CLK_MHZ     250

`endif

// >>> core/t1gr_pkg.sv
// types for the t1 global and transmit line register bank
`default_nettype none
package t1gr_pkg;

  // ----------------------------------------------------------------
  // bus answer phase
  // ----------------------------------------------------------------
  typedef enum logic {
    T1GR_IDLE,
    T1GR_ANSWER
  } t1gr_phase_type;

  // ----------------------------------------------------------------
  // whole state of the bank
  // ----------------------------------------------------------------
  typedef struct packed {
    t1gr_phase_type phase;
    logic waitreq;
    logic [7:0] rdata;
    logic [1:0] refa_pick;
    logic [1:0] refb_pick;
    logic nosig_choice;
    logic tmr_en;
    logic tmr_flag;
    logic [31:0] tmr_cnt;
    logic [1:0] perf_link;
    logic [3:0] perf_idx;
    logic [4:0] bp;
    logic [3:0][5:0] dej;
    logic [3:0] t_off;
    logic [3:0] line_code;
    logic [3:0][5:0] drv;
    logic [3:0][5:0] amp;
    logic [3:0][7:0] tram;
    logic [3:0][6:0] tdat;
    logic [3:0][6:0] gap;
    logic [3:0][63:0][6:0] ram;
    logic [3:0] rclk_s1;
    logic [3:0] rclk_s2;
    logic [3:0] nosig_s1;
    logic [3:0] nosig_s2;
    logic [15:0] pin_s1;
    logic [15:0] pin_s2;
    logic half;
    logic refa;
    logic refb;
    logic irq;
    logic [15:0] pin_sel;
    logic [3:0] drv_hiz;
    logic [3:0] track;
    logic [3:0][5:0] amp_out;
  } t1gr_state_type;

endpackage : t1gr_pkg
`default_nettype wire

// >>> core/t1gr_regs.sv
// global and per-link transmit line register bank on avalon-mm
`timescale 1ns/1ns
`default_nettype none
`include "t1gr_map.svh"

// Function
// - without signal loss, ref outputs follow recovered clock of picked link
// - on signal loss, ref outputs give master clock or high level
// - read-only summary shows one pending-interrupt bit per link
// - timer interrupt asserted only while enable and expiry flag both set
// - expiry flag set each second, cleared only by writing one
// - two-bit link pick chooses which link's counters are visible
// - four-bit index picks counter byte, 00h to 0Bh mapped
// - access data register returns the addressed counter byte
// - shared receive slave bit routes link-1 receive clock and frame
// - shared transmit slave bit routes link-1 transmit clock and frame
// - receive and transmit bits select multiplexed or non-multiplexed mode
// - bus-select bit picks multiplexed bus a or b for transmit
// - pointer gap tracks distance, or holds peak in test mode
// - wide bandwidth tracks jitter near overflow or underflow margin
// - enable bit and depth field: 128, 64 or 32 bits
// - corner bit selects 5 hz or 1.26 hz transfer corner
// - power-down bit powers transmit path down, driver high impedance
// - line-code bit selects b8zs at zero, ami at one
// - float bit floats only driver; monitor enable bit kept
// - shape selector picks template; 11xx is user waveform
// - amplitude trim scales output only in user waveform mode
// - ram address is interval number and sample index
// - per-link data field written into or read from template ram
module t1gr_regs #(
  parameter int SEC_CYCLES = `T1GR_SEC_TIME_MS * `T1GR_CLK_MHZ * 1000
) (
  input wire logic mclk_i,                        // master clock
  input wire logic rst_n_i,                       // async reset, low
  input wire logic [11:0] avs_address_i,          // byte address
  input wire logic avs_read_i,                    // read request
  input wire logic avs_write_i,                   // write request
  input wire logic [31:0] avs_writedata_i,        // write data
  input wire logic [3:0] avs_byteenable_i,        // byte lanes
  output logic [31:0] avs_readdata_o,             // read data
  output logic avs_waitrequest_o,                 // stall
  input wire logic [3:0] recovered_clk_i,         // per-link rx clock
  input wire logic [3:0] no_signal_state_i,       // per-link loss
  input wire logic [3:0] link_irq_flag_i,         // per-link pending
  input wire logic [3:0][11:0][7:0] perf_monitor_i, // counter bytes
  input wire logic [3:0][6:0] tx_gap_now_i,       // buffer distance
  input wire logic rx_all_slave_i,                // all rx slaves
  input wire logic tx_all_slave_i,                // all tx slaves
  input wire logic [3:0] rx_sys_clk_pin_i,        // rx sys clock pins
  input wire logic [3:0] rx_sys_frame_pin_i,      // rx frame pins
  input wire logic [3:0] tx_sys_clk_pin_i,        // tx sys clock pins
  input wire logic [3:0] tx_sys_frame_pin_i,      // tx frame pins
  output logic ref_clock_out_a_o,                 // reference out a
  output logic ref_clock_out_b_o,                 // reference out b
  output logic sec_timer_irq_o,                   // timer interrupt
  output logic [3:0] rx_sys_clk_o,                // chosen rx clock
  output logic [3:0] rx_sys_frame_o,              // chosen rx frame
  output logic [3:0] tx_sys_clk_o,                // chosen tx clock
  output logic [3:0] tx_sys_frame_o,              // chosen tx frame
  output logic rx_sys_shared_bus_o,               // rx multiplexed
  output logic tx_sys_shared_bus_o,               // tx multiplexed
  output logic tx_bus_pick_o,                     // 1 bus a, 0 bus b
  output logic [3:0] tx_dejitter_en_o,            // attenuator on
  output logic [3:0][1:0] tx_dejitter_depth_o,    // depth code
  output logic [3:0] tx_dejitter_corner_o,        // 0 5hz, 1 1.26hz
  output logic [3:0] tx_dejitter_track_o,         // tracking jitter
  output logic [3:0][6:0] tx_ptr_gap_o,           // gap indication
  output logic [3:0] tx_power_down_o,             // path powered down
  output logic [3:0] tx_line_code_pick_o,         // 0 b8zs, 1 ami
  output logic [3:0] tx_driver_hiz_o,             // driver floated
  output logic [3:0] driver_fail_mon_en_o,        // monitor enable
  output logic [3:0][3:0] tx_shape_pick_o,        // template code
  output logic [3:0][5:0] amp_trim_o              // active trim
);

  t1gr_pkg::t1gr_state_type s_q;
  t1gr_pkg::t1gr_state_type s_d;
  logic [9:0] idx;
  logic [1:0] lk;
  logic [7:0] wbyte;
  logic wr_ok;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // per-link register match, index bits 9:8 carry the link
  function automatic logic is_link_reg(input logic [9:0] i,
                                       input logic [7:0] ofs);
    is_link_reg = (i[7:0] == ofs);
  endfunction : is_link_reg

  // guard band in bits, deeper buffer keeps a wider band
  function automatic logic [7:0] margin_of(input logic [1:0] dp);
    case (dp)
      2'h0: margin_of = 8'h04;
      2'h1: margin_of = 8'h03;
      default: margin_of = 8'h02;
    endcase
  endfunction : margin_of

  // buffer depth from the depth code
  function automatic logic [7:0] depth_of(input logic [1:0] dp);
    case (dp)
      2'h0: depth_of = 8'h80;
      2'h1: depth_of = 8'h40;
      default: depth_of = 8'h20;
    endcase
  endfunction : depth_of

  // user waveform selected by shape code 11xx
  function automatic logic user_shape(input logic [5:0] d);
    user_shape = (d[3:2] == 2'h3);
  endfunction : user_shape

  // read mux over every mapped register
  function automatic logic [7:0] rd_byte(input logic [9:0] i);
    logic [1:0] l;
    logic [7:0] r;
    l = i[9:8];
    r = 8'h00;
    if (i == `T1GR_IDX_REF_SEL) begin
      r = {3'h0, s_q.refb_pick, 1'b0, s_q.refa_pick};
    end else if (i == `T1GR_IDX_LINK_IRQ) begin
      r = {4'h0, link_irq_flag_i};
    end else if (i == `T1GR_IDX_TMR_EN) begin
      r = {7'h00, s_q.tmr_en};
    end else if (i == `T1GR_IDX_TMR_FLAG) begin
      r = {7'h00, s_q.tmr_flag};
    end else if (i == `T1GR_IDX_WIN_SEL) begin
      r = {1'b0, s_q.perf_link, 1'b0, s_q.perf_idx};
    end else if (i == `T1GR_IDX_WIN_DATA) begin
      if (s_q.perf_idx <= `T1GR_PERF_LAST) begin
        r = perf_monitor_i[s_q.perf_link][s_q.perf_idx];
      end
    end else if (i == `T1GR_IDX_BP_CFG) begin
      r = {3'h0, s_q.bp};
    end else if (i == `T1GR_IDX_NOSIG_CFG) begin
      r = {7'h00, s_q.nosig_choice};
    end else if (is_link_reg(i, `T1GR_OFS_DEJIT)) begin
      r = {2'h0, s_q.dej[l]};
    end else if (is_link_reg(i, `T1GR_OFS_PWR_CODE)) begin
      r = {3'h0, s_q.t_off[l], 3'h0, s_q.line_code[l]};
    end else if (is_link_reg(i, `T1GR_OFS_DRV_SHAPE)) begin
      r = {2'h0, s_q.drv[l]};
    end else if (is_link_reg(i, `T1GR_OFS_AMP)) begin
      r = {2'h0, s_q.amp[l]};
    end else if (is_link_reg(i, `T1GR_OFS_TRAM_CTL)) begin
      r = s_q.tram[l];
    end else if (is_link_reg(i, `T1GR_OFS_TRAM_DATA)) begin
      r = {1'b0, s_q.tdat[l]};
    end else if (is_link_reg(i, `T1GR_OFS_GAP)) begin
      r = {1'b0, s_q.gap[l]};
    end
    rd_byte = r;
  endfunction : rd_byte

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    idx = avs_address_i[11:2];
    lk = idx[9:8];
    wbyte = avs_writedata_i[7:0];
    wr_ok = 1'b0;

    // two-stage synchronisers for pins and foreign clocks
    s_d.rclk_s1 = recovered_clk_i;
    s_d.rclk_s2 = s_q.rclk_s1;
    s_d.nosig_s1 = no_signal_state_i;
    s_d.nosig_s2 = s_q.nosig_s1;
    s_d.pin_s1 = {tx_sys_frame_pin_i, tx_sys_clk_pin_i,
                  rx_sys_frame_pin_i, rx_sys_clk_pin_i};
    s_d.pin_s2 = s_q.pin_s1;

    // bus answer: one stall cycle, then waitrequest low for one cycle
    case (s_q.phase)
      t1gr_pkg::T1GR_IDLE: begin
        s_d.waitreq = 1'b1;
        if (avs_read_i || avs_write_i) begin
          s_d.phase = t1gr_pkg::T1GR_ANSWER;
          s_d.waitreq = 1'b0;
          s_d.rdata = avs_read_i ? rd_byte(idx) : 8'h00;
        end
      end
      t1gr_pkg::T1GR_ANSWER: begin
        s_d.phase = t1gr_pkg::T1GR_IDLE;
        s_d.waitreq = 1'b1;
        wr_ok = avs_write_i && avs_byteenable_i[0];
      end
      default: begin
        s_d.phase = t1gr_pkg::T1GR_IDLE;
        s_d.waitreq = 1'b1;
      end
    endcase

    // register writes take effect at the accepting edge
    if (wr_ok) begin
      if (idx == `T1GR_IDX_REF_SEL) begin
        s_d.refa_pick = wbyte[1:0];
        s_d.refb_pick = wbyte[4:3];
      end else if (idx == `T1GR_IDX_TMR_EN) begin
        s_d.tmr_en = wbyte[0];
      end else if (idx == `T1GR_IDX_TMR_FLAG) begin
        if (wbyte[0]) begin
          s_d.tmr_flag = 1'b0;
        end
      end else if (idx == `T1GR_IDX_WIN_SEL) begin
        s_d.perf_link = wbyte[6:5];
        s_d.perf_idx = wbyte[3:0];
      end else if (idx == `T1GR_IDX_BP_CFG) begin
        s_d.bp = wbyte[4:0];
      end else if (idx == `T1GR_IDX_NOSIG_CFG) begin
        s_d.nosig_choice = wbyte[0];
      end else if (is_link_reg(idx, `T1GR_OFS_DEJIT)) begin
        s_d.dej[lk] = wbyte[5:0];
      end else if (is_link_reg(idx, `T1GR_OFS_PWR_CODE)) begin
        s_d.t_off[lk] = wbyte[4];
        s_d.line_code[lk] = wbyte[0];
      end else if (is_link_reg(idx, `T1GR_OFS_DRV_SHAPE)) begin
        s_d.drv[lk] = wbyte[5:0];
      end else if (is_link_reg(idx, `T1GR_OFS_AMP)) begin
        s_d.amp[lk] = wbyte[5:0];
      end else if (is_link_reg(idx, `T1GR_OFS_TRAM_CTL)) begin
        s_d.tram[lk] = wbyte;
      end else if (is_link_reg(idx, `T1GR_OFS_TRAM_DATA)) begin
        s_d.tdat[lk] = wbyte[6:0];
      end
    end

    // one-second timer; a tick beats a clear in the same cycle
    if (s_q.tmr_cnt == 32'(SEC_CYCLES - 1)) begin
      s_d.tmr_cnt = 32'h0000_0000;
      s_d.tmr_flag = 1'b1;
    end else begin
      s_d.tmr_cnt = s_q.tmr_cnt + 32'h0000_0001;
    end

    s_d.irq = s_d.tmr_flag && s_d.tmr_en;

    // reference outputs; master clock is carried as a half-rate toggle
    s_d.half = ~s_q.half;
    if (s_q.nosig_s2[s_q.refa_pick]) begin
      s_d.refa = s_q.nosig_choice ? 1'b1 : s_q.half;
    end else begin
      s_d.refa = s_q.rclk_s2[s_q.refa_pick];
    end
    if (s_q.nosig_s2[s_q.refb_pick]) begin
      s_d.refb = s_q.nosig_choice ? 1'b1 : s_q.half;
    end else begin
      s_d.refb = s_q.rclk_s2[s_q.refb_pick];
    end

    // per-link logic
    for (int l = 0; l < 4; l++) begin
      if (rx_all_slave_i && s_q.bp[4]) begin
        s_d.pin_sel[l] = s_q.pin_s2[0];
        s_d.pin_sel[4 + l] = s_q.pin_s2[4];
      end else begin
        s_d.pin_sel[l] = s_q.pin_s2[l];
        s_d.pin_sel[4 + l] = s_q.pin_s2[4 + l];
      end
      if (tx_all_slave_i && s_q.bp[1]) begin
        s_d.pin_sel[8 + l] = s_q.pin_s2[8];
        s_d.pin_sel[12 + l] = s_q.pin_s2[12];
      end else begin
        s_d.pin_sel[8 + l] = s_q.pin_s2[8 + l];
        s_d.pin_sel[12 + l] = s_q.pin_s2[12 + l];
      end

      if (!s_q.dej[l][`T1GR_DEJ_PEAK] || (tx_gap_now_i[l] > s_q.gap[l])) begin
        s_d.gap[l] = tx_gap_now_i[l];
      end

      s_d.track[l] = s_q.dej[l][`T1GR_DEJ_EN] && s_q.dej[l][`T1GR_DEJ_WIDE] &&
        (({1'b0, tx_gap_now_i[l]} <=
          margin_of(s_q.dej[l][`T1GR_DEJ_DP_HI:`T1GR_DEJ_DP_LO])) ||
         ({1'b0, tx_gap_now_i[l]} >=
          (depth_of(s_q.dej[l][`T1GR_DEJ_DP_HI:`T1GR_DEJ_DP_LO]) -
           margin_of(s_q.dej[l][`T1GR_DEJ_DP_HI:`T1GR_DEJ_DP_LO]))));

      s_d.drv_hiz[l] = s_q.t_off[l] || s_q.drv[l][`T1GR_DRV_FLOAT];

      // trim only in user waveform mode
      s_d.amp_out[l] = user_shape(s_q.drv[l]) ? s_q.amp[l] : 6'h00;

      // template ram access, go clears when done
      if (s_q.tram[l][`T1GR_TRAM_GO] && user_shape(s_q.drv[l])) begin
        if (s_q.tram[l][`T1GR_TRAM_RD]) begin
          s_d.tdat[l] = s_q.ram[l][s_q.tram[l][5:0]];
        end else begin
          s_d.ram[l][s_q.tram[l][5:0]] = s_q.tdat[l];
        end
        s_d.tram[l][`T1GR_TRAM_GO] = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.waitreq <= 1'b1;
      s_q.bp <= `T1GR_RST_BP;
      s_q.drv <= {4{`T1GR_RST_DRV}};
      s_q.amp <= {4{`T1GR_RST_AMP}};
      s_q.drv_hiz <= 4'hF;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign avs_readdata_o = {24'h00_0000, s_q.rdata};
  assign avs_waitrequest_o = s_q.waitreq;
  assign ref_clock_out_a_o = s_q.refa;
  assign ref_clock_out_b_o = s_q.refb;
  assign sec_timer_irq_o = s_q.irq;
  assign rx_sys_clk_o = s_q.pin_sel[3:0];
  assign rx_sys_frame_o = s_q.pin_sel[7:4];
  assign tx_sys_clk_o = s_q.pin_sel[11:8];
  assign tx_sys_frame_o = s_q.pin_sel[15:12];
  assign rx_sys_shared_bus_o = s_q.bp[3];
  assign tx_bus_pick_o = s_q.bp[2];
  assign tx_sys_shared_bus_o = s_q.bp[0];
  assign tx_ptr_gap_o = s_q.gap;
  assign tx_dejitter_track_o = s_q.track;
  assign tx_power_down_o = s_q.t_off;
  assign tx_line_code_pick_o = s_q.line_code;
  assign tx_driver_hiz_o = s_q.drv_hiz;
  assign amp_trim_o = s_q.amp_out;

  // per-link configuration fields
  generate
    for (genvar g = 0; g < 4; g++) begin : g_link
      assign tx_dejitter_en_o[g] = s_q.dej[g][`T1GR_DEJ_EN];
      assign tx_dejitter_depth_o[g] =
        s_q.dej[g][`T1GR_DEJ_DP_HI:`T1GR_DEJ_DP_LO];
      assign tx_dejitter_corner_o[g] = s_q.dej[g][`T1GR_DEJ_CORNER];
      assign driver_fail_mon_en_o[g] = s_q.drv[g][`T1GR_DRV_DFM];
      assign tx_shape_pick_o[g] = s_q.drv[g][3:0];
    end
  endgenerate

endmodule : t1gr_regs
`default_nettype wire

// >>> dv/t1gr_regs_monitor.sv
// port-level checks for the t1 register bank
`timescale 1ns/1ns
`default_nettype none
module t1gr_regs_monitor #(
  parameter int SEC_CYCLES = 20
) (
  input wire logic mclk_i, // master clock
  input wire logic rst_n_i, // async reset, low
  input wire logic [11:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [31:0] avs_readdata_o, // read data
  input wire logic avs_waitrequest_o, // stall
  input wire logic [3:0] link_irq_flag_i, // per-link pending
  input wire logic [3:0][6:0] tx_gap_now_i, // buffer distance
  input wire logic sec_timer_irq_o, // timer interrupt
  input wire logic [3:0] tx_dejitter_en_o, // attenuator on
  input wire logic [3:0] tx_dejitter_track_o, // tracking
  input wire logic [3:0][6:0] tx_ptr_gap_o, // gap indication
  input wire logic [3:0] tx_power_down_o, // powered down
  input wire logic [3:0] tx_driver_hiz_o, // driver floated
  input wire logic [3:0][3:0] tx_shape_pick_o, // template code
  input wire logic [3:0][5:0] amp_trim_o // active trim
);
  // ------------------------------------------------------------
  // bus handshake and register behaviour
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_answer;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no answer one cycle after request");
  property p_one;
    $fell(avs_waitrequest_o) |=> avs_waitrequest_o;
  endproperty
  a_one: assert property (p_one)
    else $error("answer longer than one cycle");
  property p_rest;
    !avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_rest: assert property (p_rest)
    else $error("answer without request");
  property p_zero;
    !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000;
  endproperty
  a_zero: assert property (p_zero)
    else $error("upper read data not zero");
  property p_summary;
    avs_read_i && avs_waitrequest_o && avs_address_i[11:2] == 10'h009
      |=> avs_readdata_o == {28'h0000000, $past(link_irq_flag_i)};
  endproperty
  a_summary: assert property (p_summary)
    else $error("link summary mismatch");
  // the interrupt is a level: only a bus write may take it down
  property p_irq_hold;
    $fell(sec_timer_irq_o) |-> $past(avs_write_i && !avs_waitrequest_o);
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("timer interrupt dropped without write");
  property p_hiz;
    1'b1 |=> (tx_driver_hiz_o & $past(tx_power_down_o))
      == $past(tx_power_down_o);
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("powered-down driver not floated");
  property p_amp;
    tx_shape_pick_o[0][3:2] != 2'b11 && $stable(tx_shape_pick_o[0])
      |-> amp_trim_o[0] == 6'h00;
  endproperty
  a_amp: assert property (p_amp)
    else $error("trim active outside user waveform");
  // start only out of reset: the edge of release still loads zero
  property p_gap;
    rst_n_i |=> tx_ptr_gap_o[0] >= $past(tx_gap_now_i[0]);
  endproperty
  a_gap: assert property (p_gap)
    else $error("gap below current distance");
  property p_track;
    tx_dejitter_track_o[0] |-> tx_dejitter_en_o[0] || $past(tx_dejitter_en_o[0]);
  endproperty
  a_track: assert property (p_track)
    else $error("tracking while attenuator off");
endmodule : t1gr_regs_monitor

bind t1gr_regs t1gr_regs_monitor #(.SEC_CYCLES(SEC_CYCLES)) i_mon (
  .mclk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_readdata_o, .avs_waitrequest_o, .link_irq_flag_i, .tx_gap_now_i,
  .sec_timer_irq_o, .tx_dejitter_en_o, .tx_dejitter_track_o,
  .tx_ptr_gap_o, .tx_power_down_o, .tx_driver_hiz_o, .tx_shape_pick_o,
  .amp_trim_o
);
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the t1 register bank
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int SEC = 20;
  // rows: address, reset value, write value, read-back value
  localparam logic [35:0] ROWS [14] = '{
    36'h01C000B0B, 36'h0240AFF0A, 36'h028000101, 36'h038006B6B,
    36'h03CBBFFBB, 36'h04016FF1F, 36'h084003F3F, 36'h08800FF11,
    36'h08C103C3C, 36'h09021FF3F, 36'h0F800FF01, 36'h00400FF00,
    36'hC88001010, 36'h09800FF7F};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] adr = 12'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] template_wr_value = 32'h00000000;
  logic [3:0] rclk = 4'h0;
  logic [3:0] nosig = 4'h0;
  logic [3:0] lirq = 4'hA;
  logic [3:0][11:0][7:0] perf;
  logic [3:0][6:0] gap = '0;
  logic sl = 1'b1;
  logic [3:0] rpin = 4'h1;
  logic [3:0] tpin = 4'h1;
  logic [31:0] rdat;
  logic wreq, ra, rb, irq, rxm, txm, pick;
  logic [3:0] rsc, rsf, tsc, tsf, den, dcor, trk, pd, lc, hiz, mon;
  logic [3:0][1:0] ddep;
  logic [3:0][6:0] gapo;
  logic [3:0][5:0] amp;
  logic [3:0][3:0] shp;
  int mismatches = 0;
  int num_checks = 0;

  // 250 mhz master clock
  always #2 mclk = ~mclk;

  t1gr_regs #(.SEC_CYCLES(SEC)) i_dut (
    .mclk_i(mclk), .rst_n_i(rst_n), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(template_wr_value),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .recovered_clk_i(rclk),
    .no_signal_state_i(nosig), .link_irq_flag_i(lirq),
    .perf_monitor_i(perf), .tx_gap_now_i(gap), .rx_all_slave_i(sl),
    .tx_all_slave_i(sl), .rx_sys_clk_pin_i(rpin),
    .rx_sys_frame_pin_i(rpin), .tx_sys_clk_pin_i(tpin),
    .tx_sys_frame_pin_i(tpin), .ref_clock_out_a_o(ra),
    .ref_clock_out_b_o(rb), .sec_timer_irq_o(irq), .rx_sys_clk_o(rsc),
    .rx_sys_frame_o(rsf), .tx_sys_clk_o(tsc), .tx_sys_frame_o(tsf),
    .rx_sys_shared_bus_o(rxm), .tx_sys_shared_bus_o(txm),
    .tx_bus_pick_o(pick), .tx_dejitter_en_o(den),
    .tx_dejitter_depth_o(ddep), .tx_dejitter_corner_o(dcor),
    .tx_dejitter_track_o(trk), .tx_ptr_gap_o(gapo),
    .tx_power_down_o(pd), .tx_line_code_pick_o(lc),
    .tx_driver_hiz_o(hiz), .driver_fail_mon_en_o(mon),
    .tx_shape_pick_o(shp), .amp_trim_o(amp));

  task automatic report_and_stop();
    if (mismatches == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [11:0] a,
      input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    adr <= a;
    template_wr_value <= {24'h000000, d};
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge mclk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk);
    if (n == 50) begin
      mismatches++;
      report_and_stop();
    end
  endtask : bus

  task automatic wrt(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wrt

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask : rd_chk

  initial begin
    logic [31:0] q;
    for (int l = 0; l < 4; l++)
      for (int i = 0; i < 12; i++)
        perf[l][i] = {2'b10, l[1:0], i[3:0]};
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    // reset value, write, read back for each row of the table
    foreach (ROWS[k]) begin
      rd_chk(ROWS[k][35:24], ROWS[k][23:16]);
      wrt(ROWS[k][35:24], ROWS[k][15:8]);
      rd_chk(ROWS[k][35:24], ROWS[k][7:0]);
    end
    chk({amp[0], pd, hiz, lc, mon, den, ddep[0], dcor},
        {6'h3F, 4'h9, 4'hF, 4'h1, 4'h1, 4'h1, 2'h3, 4'h1});
    chk(shp, 16'h000C);
    // reference outputs follow picked links, then loss handling
    rclk <= 4'h8;
    repeat (6) @(posedge mclk);
    chk({ra, rb}, 2'b10);
    rclk <= 4'h2;
    repeat (6) @(posedge mclk);
    chk({ra, rb}, 2'b01);
    nosig <= 4'hF;
    repeat (6) @(posedge mclk);
    chk({ra, rb}, 2'b11);
    wrt(12'h0F8, 8'h00);
    repeat (6) @(posedge mclk);
    q[0] = ra;
    @(posedge mclk);
    chk(q[0] ^ ra, 1);
    // shared slave pins and bus modes
    chk({rsc, rsf, tsc, tsf, rxm, txm, pick}, {16'hFFFF, 3'h7});
    wrt(12'h040, 8'h00);
    repeat (6) @(posedge mclk);
    chk({rsc, rsf, tsc, tsf, rxm, txm, pick}, {16'h1111, 3'h0});
    // tracking near the margin, then peak hold of the gap
    gap[0] <= 7'd1;
    wrt(12'h084, 8'h1C);
    repeat (3) @(posedge mclk);
    chk({trk, gapo[0]}, {4'h1, 7'd1});
    gap[0] <= 7'd16;
    repeat (3) @(posedge mclk);
    chk({trk, gapo[0]}, {4'h0, 7'd16});
    wrt(12'h084, 8'h3C);
    gap[0] <= 7'd30;
    repeat (3) @(posedge mclk);
    gap[0] <= 7'd5;
    repeat (3) @(posedge mclk);
    chk(gapo[0], 30);
    wrt(12'h084, 8'h1C);
    repeat (3) @(posedge mclk);
    chk(gapo[0], 5);
    // timer flag: set each period, write-one-to-clear, enable gate
    // clear first and wait for a fresh tick, so no later clear meets a tick
    for (int n = 0; n < 4 && irq !== 1'b0; n++) wrt(12'h02C, 8'h01);
    for (int n = 0; n < 3 * SEC && irq !== 1'b1; n++) @(posedge mclk);
    chk(irq, 1);
    wrt(12'h02C, 8'h00);
    chk(irq, 1);
    wrt(12'h02C, 8'h01);
    chk(irq, 0);
    wrt(12'h028, 8'h00);
    q = 0;
    for (int n = 0; n < 3 * SEC && q[0] !== 1'b1; n++)
      bus(1'b0, 12'h02C, 8'h00, q);
    chk({q[0], irq}, 2'b10);
    // template ram write then read back through the data field
    wrt(12'h098, 8'h55);
    wrt(12'h094, 8'hA5);
    rd_chk(12'h094, 8'h25);
    wrt(12'h098, 8'h00);
    wrt(12'h094, 8'hE5);
    rd_chk(12'h098, 8'h55);
    wrt(12'h08C, 8'h02);
    wrt(12'h094, 8'h80);
    rd_chk(12'h094, 8'h80);
    chk(amp[0], 0);
    wrt(12'h088, 8'h01);
    @(posedge mclk);
    chk({pd, hiz}, 8'h8E);
    // second reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd_chk(12'h040, 8'h16);
    chk(hiz, 4'hF);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
